// *** rtl/adcts_pkg.sv ***
// constants, field layout and timing counts of the converter timing and status block
// assumes an 8-bit register port and a system clock that is the high-frequency clock
// Functional notes
// - after mode/channel register is written zero, starts are refused for four cycles
// - ladder bit 0 connects ladder only while converting, 1 keeps it connected
// - time code 000=39,010=78,011=156,100=312,101=624,110=1248 clocks; 001,111 reserved
// - timing register bits 7 and 6 carry no defined value on read
// - stop mode resets timing register and blocks writes to it until normal mode
// - done flag reads 0 before or during conversion, 1 once it completed; in repeat mode the code leaves it 1 as the next conversion starts
// - busy flag sets at conversion start, clears at finish and on stop entry
// - reading high result clears done flag, so software reads low register first
// - low result/status bits 3 to 0 carry no defined value on read
// - low result/status at 0x28: result bits 1,0, done, busy; top four reset zero
// - completion stores result, sets done flag and raises done interrupt together
// - start bit clears itself once the conversion has begun
package adcts_pkg;
    // register offsets
    localparam logic [7:0] OFS_MODE_CHANNEL_CTRL = 8'h20;
    localparam logic [7:0] OFS_TIMING_CONTROL = 8'h21;
    localparam logic [7:0] OFS_RESULT_LOW_STATUS = 8'h28;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h29;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h2a;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h2b;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h2c;

    // mode/channel control fields
    localparam int MODE_START_POS = 7;
    localparam int MODE_AMD_POS = 5;
    localparam int MODE_INDIS_POS = 4;
    localparam int MODE_CHAN_POS = 0;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // timing control fields
    localparam int TIME_LADDER_POS = 5;
    localparam int TIME_ACK_POS = 1;
    localparam logic [7:0] TIME_RESET = 8'h00;
    localparam logic [7:0] TIME_WRITE_MASK = 8'h3f;

    // low result/status fields
    localparam int LOW_RES1_POS = 7;
    localparam int LOW_RES0_POS = 6;
    localparam int LOW_DONE_POS = 5;
    localparam int LOW_BUSY_POS = 4;

    // restart guard length after mode register cleared
    localparam logic [2:0] GUARD_CYCLES = 3'h4;

    // conversion lengths in high-frequency clock periods
    localparam logic [10:0] CT_39 = 11'h027;
    localparam logic [10:0] CT_78 = 11'h04e;
    localparam logic [10:0] CT_156 = 11'h09c;
    localparam logic [10:0] CT_312 = 11'h138;
    localparam logic [10:0] CT_624 = 11'h270;
    localparam logic [10:0] CT_1248 = 11'h4e0;

    // operating modes
    typedef enum logic [1:0] {
        AMD_DISABLE = 2'b00,
        AMD_SOFTWARE = 2'b01,
        AMD_RESERVED = 2'b10,
        AMD_REPEAT = 2'b11
    } adcts_mode_type;
endpackage : adcts_pkg

// *** rtl/adcts_conv_timer.sv ***
// conversion sequencer counting clock periods of the selected conversion time
// assumes start while busy only comes on the last period, and abort wins over start
`timescale 1ns/100ps
`default_nettype none
module adcts_conv_timer #(
    parameter int LEN_W = 11
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [LEN_W-1:0] len_i,
    output logic busy_o,
    output logic done_o
);
    logic [LEN_W-1:0] cnt_q;
    logic run_q;

    // completion on the last period of the count
    assign done_o = run_q && (cnt_q == '0) && ce_i && !abort_i;
    assign busy_o = run_q;

    // count down from length minus one; a start on the last period chains the next conversion
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q <= 1'b0;
            cnt_q <= '0;
        end else if (ce_i) begin
            if (abort_i) begin
                run_q <= 1'b0;
                cnt_q <= '0;
            end else if (start_i && (!run_q || (cnt_q == '0))) begin
                run_q <= 1'b1;
                cnt_q <= len_i - LEN_W'(1);
            end else if (run_q) begin
                if (cnt_q == '0) begin
                    run_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - LEN_W'(1);
                end
            end
        end
    end
endmodule : adcts_conv_timer
`default_nettype wire

// *** rtl/adcts_top.sv ***
// timing selection, ladder control, restart guard and status of the converter
// assumes the comparator array supplies a settled 10-bit result at completion
`timescale 1ns/100ps
`default_nettype none
module adcts_top #(
    parameter int RES_W = 10
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic stop_mode_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [RES_W-1:0] conv_result_i,
    output logic ladder_connect_o,
    output logic conv_active_o,
    output logic [3:0] channel_sel_o,
    output logic input_disable_o,
    output logic irq_o
);
    import adcts_pkg::*;

    logic rst_meta_q;
    logic rst_n;
    logic start_q;
    adcts_mode_type mode_q;
    logic indis_q;
    logic [3:0] chan_q;
    logic ladder_always_on_q;
    logic [2:0] ack_q;
    logic [7:0] time_q;
    logic [2:0] guard_q;
    logic conv_done_flag_q;
    logic [RES_W-1:0] result_q;
    logic irq_stat_q;
    logic irq_en_q;
    logic [7:0] rdata_q;
    logic [10:0] len_w;
    logic busy_w;
    logic done_w;
    logic wr_mode_w;
    logic wr_time_w;
    logic rd_high_w;
    logic mode_zero_w;
    logic abort_w;
    logic start_take_w;
    logic repeat_take_w;
    logic begin_w;
    logic [10:0] chk_len_q;
    logic [10:0] chk_cnt_q;

    // reset release through two flops
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // register port decode
    assign wr_mode_w = reg_wr_i && (reg_addr_i == OFS_MODE_CHANNEL_CTRL) && !stop_mode_i;
    assign wr_time_w = reg_wr_i && (reg_addr_i == OFS_TIMING_CONTROL) && !stop_mode_i;
    assign rd_high_w = reg_rd_i && (reg_addr_i == OFS_RESULT_HIGH);
    assign mode_zero_w = wr_mode_w && (reg_wdata_i == 8'h00);

    // leaving to disable mode or stop cuts a running conversion short
    assign abort_w = stop_mode_i ||
        (wr_mode_w && (reg_wdata_i[MODE_AMD_POS+:2] == AMD_DISABLE));

    // software start, blocked by guard, busy and invalid modes
    assign start_take_w = start_q && (guard_q == 3'h0) && !busy_w &&
        ((mode_q == AMD_SOFTWARE) || (mode_q == AMD_REPEAT));
    // repeat mode restarts on each completion
    assign repeat_take_w = done_w && (mode_q == AMD_REPEAT);
    assign begin_w = (start_take_w || repeat_take_w) && !abort_w && ce_i;

    // conversion length from the time code; reserved codes fall back to longest
    always_comb begin
        unique case (ack_q)
            3'b000: len_w = CT_39;
            3'b010: len_w = CT_78;
            3'b011: len_w = CT_156;
            3'b100: len_w = CT_312;
            3'b101: len_w = CT_624;
            3'b110: len_w = CT_1248;
            default: len_w = CT_1248;
        endcase
    end

    adcts_conv_timer #(
        .LEN_W(11)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .start_i(begin_w),
        .abort_i(abort_w),
        .len_i(len_w),
        .busy_o(busy_w),
        .done_o(done_w)
    );

    // mode/channel register; cleared and locked in stop mode
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= adcts_mode_type'(MODE_RESET[MODE_AMD_POS+:2]);
            indis_q <= MODE_RESET[MODE_INDIS_POS];
            chan_q <= MODE_RESET[MODE_CHAN_POS+:4];
        end else if (ce_i) begin
            if (stop_mode_i) begin
                mode_q <= adcts_mode_type'(MODE_RESET[MODE_AMD_POS+:2]);
                indis_q <= MODE_RESET[MODE_INDIS_POS];
                chan_q <= MODE_RESET[MODE_CHAN_POS+:4];
            end else if (wr_mode_w) begin
                mode_q <= adcts_mode_type'(reg_wdata_i[MODE_AMD_POS+:2]);
                indis_q <= reg_wdata_i[MODE_INDIS_POS];
                chan_q <= reg_wdata_i[MODE_CHAN_POS+:4];
            end
        end
    end

    // start bit, cleared once the conversion has begun
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= MODE_RESET[MODE_START_POS];
        end else if (ce_i) begin
            if (stop_mode_i || begin_w) begin
                start_q <= 1'b0;
            end else if (wr_mode_w) begin
                start_q <= reg_wdata_i[MODE_START_POS] &&
                    (reg_wdata_i[MODE_AMD_POS+:2] != AMD_DISABLE);
            end else if ((mode_q == AMD_DISABLE) || (mode_q == AMD_RESERVED)) begin
                start_q <= 1'b0;
            end
        end
    end

    // restart guard after the mode register is written all zero
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            guard_q <= 3'h0;
        end else if (ce_i) begin
            if (mode_zero_w) begin
                guard_q <= GUARD_CYCLES;
            end else if (guard_q != 3'h0) begin
                guard_q <= guard_q - 3'h1;
            end
        end
    end

    // timing control register; reset and write-locked in stop mode
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            time_q <= TIME_RESET;
        end else if (ce_i) begin
            if (stop_mode_i) begin
                time_q <= TIME_RESET;
            end else if (wr_time_w) begin
                time_q <= reg_wdata_i & TIME_WRITE_MASK;
            end
        end
    end
    assign ladder_always_on_q = time_q[TIME_LADDER_POS];
    assign ack_q = time_q[TIME_ACK_POS+:3];

    // done flag: completion sets, high-result read or a new start clears
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            conv_done_flag_q <= 1'b0;
        end else if (ce_i) begin
            if (stop_mode_i) begin
                conv_done_flag_q <= 1'b0;
            end else if (done_w) begin
                conv_done_flag_q <= 1'b1;
            end else if (rd_high_w || begin_w) begin
                conv_done_flag_q <= 1'b0;
            end
        end
    end

    // result capture at completion; aborted conversions store nothing
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= '0;
        end else if (ce_i) begin
            if (stop_mode_i) begin
                result_q <= '0;
            end else if (done_w) begin
                result_q <= conv_result_i;
            end
        end
    end

    // interrupt status, enable and clear; set wins over clear
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else if (ce_i) begin
            if (done_w) begin
                irq_stat_q <= 1'b1;
            end else if (reg_wr_i && (reg_addr_i == OFS_IRQ_CLEAR) && reg_wdata_i[0]) begin
                irq_stat_q <= 1'b0;
            end
            if (reg_wr_i && (reg_addr_i == OFS_IRQ_ENABLE)) begin
                irq_en_q <= reg_wdata_i[0];
            end
        end
    end
    assign irq_o = irq_stat_q && irq_en_q;

    // read data, one cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (ce_i) begin
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    OFS_MODE_CHANNEL_CTRL: rdata_q <= {start_q, mode_q, indis_q, chan_q};
                    OFS_TIMING_CONTROL: rdata_q <= {2'b00, time_q[5:0]};
                    OFS_RESULT_LOW_STATUS: rdata_q <= {result_q[1], result_q[0],
                        conv_done_flag_q, busy_w, 4'h0};
                    OFS_RESULT_HIGH: rdata_q <= result_q[RES_W-1:2];
                    OFS_IRQ_STATUS: rdata_q <= {7'h00, irq_stat_q};
                    OFS_IRQ_ENABLE: rdata_q <= {7'h00, irq_en_q};
                    default: rdata_q <= 8'h00;
                endcase
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end
    assign reg_rdata_o = rdata_q;

    // ladder tied in while converting, or always when selected
    assign ladder_connect_o = (ladder_always_on_q || busy_w) && !stop_mode_i;
    assign conv_active_o = busy_w;
    assign channel_sel_o = chan_q;
    assign input_disable_o = indis_q;

    // reference count of clock periods since the conversion began, read only by assertions
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            chk_len_q <= 11'h000;
            chk_cnt_q <= 11'h000;
        end else if (ce_i) begin
            if (begin_w) begin
                chk_len_q <= len_w;
                chk_cnt_q <= 11'h001;
            end else if (busy_w) begin
                chk_cnt_q <= chk_cnt_q + 11'h001;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n || !ce_i);

    property p_guard;
        mode_zero_w |=> !begin_w [*4];
    endproperty
    a_guard: assert property (p_guard) else $error("start taken inside guard");

    property p_ladder;
        !stop_mode_i |-> (ladder_connect_o == (ladder_always_on_q || busy_w));
    endproperty
    a_ladder: assert property (p_ladder) else $error("ladder connection wrong");

    property p_len39;
        (begin_w && ack_q == 3'b000) ##1 (!abort_w && !stop_mode_i) [*8] |-> ##31 done_w;
    endproperty
    a_len39: assert property (p_len39) else $error("short conversion length wrong");

    property p_done_flag;
        done_w && !stop_mode_i |=> conv_done_flag_q;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag not set");

    property p_busy;
        begin_w |=> busy_w;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not set at start");

    property p_stop;
        stop_mode_i |=> !busy_w && (time_q == TIME_RESET) && !conv_done_flag_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not initialise");

    property p_high_read;
        rd_high_w && !done_w |=> !conv_done_flag_q;
    endproperty
    a_high_read: assert property (p_high_read) else $error("high read kept done flag");

    property p_low_read;
        reg_rd_i && reg_addr_i == OFS_RESULT_LOW_STATUS |=>
            reg_rdata_o[3:0] == 4'h0 && reg_rdata_o[5] == $past(conv_done_flag_q);
    endproperty
    a_low_read: assert property (p_low_read) else $error("low status read wrong");

    property p_irq;
        done_w |=> irq_stat_q && result_q == $past(conv_result_i);
    endproperty
    a_irq: assert property (p_irq) else $error("completion not recorded");

    property p_start_clear;
        begin_w |=> !start_q;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start bit stuck");

    property p_busy_end;
        done_w && (mode_q != AMD_REPEAT) |=> !busy_w;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy kept after completion");

    property p_repeat;
        done_w && (mode_q == AMD_REPEAT) |=> busy_w;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat mode did not restart");

    property p_start_clears_done;
        begin_w && !done_w |=> !conv_done_flag_q;
    endproperty
    a_start_clears_done: assert property (p_start_clears_done) else $error("done flag kept at start");

    property p_time_read;
        reg_rd_i && (reg_addr_i == OFS_TIMING_CONTROL) |=> (reg_rdata_o[7:6] == 2'b00);
    endproperty
    a_time_read: assert property (p_time_read) else $error("timing top bits not zero");

    property p_guard_load;
        mode_zero_w |=> (guard_q == GUARD_CYCLES);
    endproperty
    a_guard_load: assert property (p_guard_load) else $error("guard not loaded");

    property p_stop_ladder;
        stop_mode_i |-> !ladder_connect_o;
    endproperty
    a_stop_ladder: assert property (p_stop_ladder) else $error("ladder tied in during stop");

    property p_len_count;
        done_w |-> (chk_cnt_q == chk_len_q);
    endproperty
    a_len_count: assert property (p_len_count) else $error("conversion length differs from code");
endmodule : adcts_top
`default_nettype wire

// *** tb/test_adcts_top.sv ***
// self-checking bench of the converter timing and status block
// assumes the register map and timing given by adcts_pkg, one 10 MHz clock
`timescale 1ns/100ps
`default_nettype none
module test_adcts_top;
    import adcts_pkg::*;

    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ce_i = 1'b1;
    logic stop_mode_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [9:0] conv_result_i = 10'h000;
    logic [7:0] reg_rdata_o;
    logic ladder_connect_o;
    logic conv_active_o;
    logic [3:0] channel_sel_o;
    logic input_disable_o;
    logic irq_o;
    int errors = 0;
    int n_checks = 0;
    int act_cnt = 0;
    logic lad_chk = 1'b0;
    logic lad_bad = 1'b0;
    logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    int lens [6] = '{39, 78, 156, 312, 624, 1248};

    adcts_top uut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .stop_mode_i(stop_mode_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .conv_result_i(conv_result_i), .ladder_connect_o(ladder_connect_o),
        .conv_active_o(conv_active_o), .channel_sel_o(channel_sel_o), .input_disable_o(input_disable_o),
        .irq_o(irq_o)
    );

    // 100 ns clock
    always #50 sys_clk_i = ~sys_clk_i;

    // busy length counter, cleared by each mode write, and ladder watch while the ladder bit is 0
    always @(posedge sys_clk_i) begin
        if (reg_wr_i && reg_addr_i == OFS_MODE_CHANNEL_CTRL) begin
            act_cnt <= 0;
        end else if (conv_active_o === 1'b1) begin
            act_cnt <= act_cnt + 1;
        end
        if (lad_chk && ladder_connect_o !== (conv_active_o & ~stop_mode_i)) lad_bad <= 1'b1;
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one-cycle write strobe, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : wr

    // one-cycle read strobe, data compared in the following cycle under a mask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 check(nm, reg_rdata_o & m, e);
        @(posedge sys_clk_i);
    endtask : rd

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // watchdog well beyond the expected run of about 2800 cycles
    initial begin
        #(20000 * 100);
        errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        int i;
        int k;
        logic [9:0] res;
        logic [9:0] prev;
        prev = 10'h000;
        repeat (10) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        lad_chk <= 1'b1;
        // reset values, unmapped and read-only places
        rd(OFS_RESULT_LOW_STATUS, 8'hff, 8'h00, "low status reset");
        rd(OFS_TIMING_CONTROL, 8'hff, 8'h00, "timing reset");
        wr(OFS_RESULT_LOW_STATUS, 8'hff);
        rd(OFS_RESULT_LOW_STATUS, 8'hff, 8'h00, "low status write ignored");
        rd(8'h3f, 8'hff, 8'h00, "unmapped read");
        wr(OFS_TIMING_CONTROL, 8'hd0);
        rd(OFS_TIMING_CONTROL, 8'hff, 8'h10, "timing top bits");
        wr(OFS_IRQ_ENABLE, 8'h00);
        // one software-start conversion for every legal time code
        for (i = 0; i < 6; i++) begin
            res = 10'h2c5 + 10'(i * 37);
            conv_result_i <= res;
            wr(OFS_TIMING_CONTROL, {4'h1, codes[i], 1'b0});
            rd(OFS_TIMING_CONTROL, 8'hff, {4'h1, codes[i], 1'b0}, "timing readback");
            wr(OFS_MODE_CHANNEL_CTRL, 8'ha4);
            rd(OFS_RESULT_LOW_STATUS, 8'hff, {prev[1:0], 6'h10}, "status while busy");
            rd(OFS_MODE_CHANNEL_CTRL, 8'hff, 8'h24, "start bit self clear");
            check("channel", {4'h0, channel_sel_o}, 8'h04);
            for (k = 0; k < 1400 && conv_active_o !== 1'b0; k++) @(negedge sys_clk_i);
            @(posedge sys_clk_i);
            check("conv ended", {7'h0, conv_active_o}, 8'h00);
            check("conv length ok", {7'h0, act_cnt == lens[i]}, 8'h01);
            check("masked irq", {7'h0, irq_o}, {7'h0, i != 0});
            @(posedge sys_clk_i);
            rd(OFS_IRQ_STATUS, 8'h01, 8'h01, "irq status");
            rd(OFS_RESULT_LOW_STATUS, 8'hff, {res[1:0], 6'h20}, "status done");
            rd(OFS_RESULT_HIGH, 8'hff, res[9:2], "result high");
            rd(OFS_RESULT_LOW_STATUS, 8'hff, {res[1:0], 6'h00}, "done cleared");
            wr(OFS_IRQ_ENABLE, 8'h01);
            check("irq enabled", {7'h0, irq_o}, 8'h01);
            wr(OFS_IRQ_CLEAR, 8'h01);
            check("irq cleared", {7'h0, irq_o}, 8'h00);
            prev = res;
        end
        // restart guard after the mode register is cleared
        @(posedge sys_clk_i);
        wr(OFS_MODE_CHANNEL_CTRL, 8'h00);
        wr(OFS_MODE_CHANNEL_CTRL, 8'ha4);
        #1 check("guard k+3", {7'h0, conv_active_o}, 8'h00);
        @(posedge sys_clk_i);
        #1 check("guard k+4", {7'h0, conv_active_o}, 8'h00);
        @(posedge sys_clk_i);
        #1 check("guard released", {7'h0, conv_active_o}, 8'h01);
        repeat (8) @(posedge sys_clk_i);
        wr(OFS_MODE_CHANNEL_CTRL, 8'h00);
        repeat (6) @(posedge sys_clk_i);
        // stop mode during a long conversion
        wr(OFS_TIMING_CONTROL, 8'h1c);
        wr(OFS_MODE_CHANNEL_CTRL, 8'ha4);
        repeat (5) @(posedge sys_clk_i);
        stop_mode_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1 check("active in stop", {7'h0, conv_active_o}, 8'h00);
        @(posedge sys_clk_i);
        rd(OFS_RESULT_LOW_STATUS, 8'h10, 8'h00, "busy in stop");
        wr(OFS_TIMING_CONTROL, 8'h3a);
        rd(OFS_TIMING_CONTROL, 8'hff, 8'h00, "timing in stop");
        rd(OFS_MODE_CHANNEL_CTRL, 8'hff, 8'h00, "mode in stop");
        stop_mode_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rd(OFS_TIMING_CONTROL, 8'hff, 8'h00, "timing after stop");
        // repeat mode keeps converting until the mode is cleared
        wr(OFS_TIMING_CONTROL, 8'h10);
        wr(OFS_MODE_CHANNEL_CTRL, 8'hf3);
        check("input disable", {7'h0, input_disable_o}, 8'h01);
        check("repeat channel", {4'h0, channel_sel_o}, 8'h03);
        repeat (100) @(posedge sys_clk_i);
        rd(OFS_RESULT_LOW_STATUS, 8'hff, {conv_result_i[1:0], 6'h30}, "repeat status");
        rd(OFS_RESULT_HIGH, 8'hff, conv_result_i[9:2], "repeat result");
        wr(OFS_MODE_CHANNEL_CTRL, 8'h00);
        check("repeat stopped", {7'h0, conv_active_o}, 8'h00);
        check("ladder follows busy", {7'h0, lad_bad}, 8'h00);
        // ladder kept on when idle
        lad_chk <= 1'b0;
        wr(OFS_TIMING_CONTROL, 8'h30);
        #1 check("ladder always on", {7'h0, ladder_connect_o}, 8'h01);
        @(posedge sys_clk_i);
        give_verdict();
    end
endmodule : test_adcts_top
`default_nettype wire
